// *** rtl/ecc_pkg.sv ***
// Package for the encoder counter configuration block.
// Assumes one 100 MHz module clock and a word-wide object write port.
package ecc_pkg;

  // Object addresses (index and subindex packed as 24 bits)
  localparam logic [23:0] ECC_ADDR_PROTECT = 24'hf00800;
  localparam logic [23:0] ECC_ADDR_RESTORE = 24'h101101;
  localparam logic [23:0] ECC_ADDR_IDX_RST = 24'h800001;
  localparam logic [23:0] ECC_ADDR_EXT_RST = 24'h800002;
  localparam logic [23:0] ECC_ADDR_UPDOWN = 24'h800003;
  localparam logic [23:0] ECC_ADDR_EDGE_SEL = 24'h800010;
  localparam logic [23:0] ECC_ADDR_FILTER = 24'h80001b;
  localparam logic [23:0] ECC_ADDR_MEAS = 24'h80001c;

  // Magic values
  localparam logic [31:0] ECC_PROTECT_CODE = 32'h12345678;
  localparam logic [31:0] ECC_RESTORE_CODE = 32'h64616f6c;

  // Reset and delivery values
  localparam logic [31:0] ECC_RST_PROTECT = 32'h00000000;
  localparam logic [31:0] ECC_RST_RESTORE = 32'h00000000;
  localparam logic ECC_RST_IDX_RST = 1'h0;
  localparam logic ECC_RST_EXT_RST = 1'h0;
  localparam logic ECC_RST_UPDOWN = 1'h0;
  localparam logic ECC_RST_EDGE_SEL = 1'h1;
  localparam logic [31:0] ECC_RST_FILTER = 32'h00000000;
  localparam logic [15:0] ECC_RST_MEAS = 16'h0000;
  localparam logic [31:0] ECC_RST_COUNT = 32'h00000000;

  // Highest valid measurement mode
  localparam logic [15:0] ECC_MEAS_MAX = 16'h0005;

  // Backed-up configuration
  typedef struct packed {
    logic index_reset_enable;
    logic latch_input_reset_enable;
    logic updown_count_enable;
    logic latch_reset_edge_select;
    logic [31:0] workpiece_filter_count;
    logic [15:0] edge_measure_select;
  } ecc_cfg_s;

  localparam ecc_cfg_s ECC_CFG_DEFAULT = '{
    index_reset_enable: ECC_RST_IDX_RST,
    latch_input_reset_enable: ECC_RST_EXT_RST,
    updown_count_enable: ECC_RST_UPDOWN,
    latch_reset_edge_select: ECC_RST_EDGE_SEL,
    workpiece_filter_count: ECC_RST_FILTER,
    edge_measure_select: ECC_RST_MEAS
  };

  // Encoder track levels
  typedef struct packed {
    logic a;
    logic b;
    logic index;
    logic latch;
  } ecc_trk_s;

endpackage : ecc_pkg

// *** rtl/ecc_sync.sv ***
// Two-flop synchroniser with edge outputs for the encoder tracks.
// Assumes asynchronous pin inputs; edges are one-cycle pulses on i_ref_clk.
`timescale 1ns/100ps
`default_nettype none
module ecc_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Pins
  input wire logic [WIDTH-1:0] i_pin,
  // Synchronised level and edges
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise,
  output logic [WIDTH-1:0] o_fall
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_stable;
  logic [WIDTH-1:0] next_prev;

  // First flop feeds only the second
  always_comb begin
    next_meta = i_pin;
    next_stable = meta;
    next_prev = stable;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      meta <= '0;
      stable <= '0;
      prev <= '0;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
    end
  end

  assign o_level = prev;
  assign o_rise = stable & ~prev;
  assign o_fall = ~stable & prev;

endmodule : ecc_sync
`default_nettype wire

// *** rtl/ecc_top.sv ***
// Encoder counter with its configuration objects and parameter store.
// Assumes a master writing 24-bit object addresses with one-cycle strobes
// and a store controller that acknowledges each save request.
// Track pins are asynchronous and pass a two-flop synchroniser first.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Writing 0x12345678 to the protection word enters save-inhibit mode.
// - While inhibited no new save is requested, a pending one stays until acknowledged; it ends on another word or restart.
// - Writing 0x64616f6c to the restore entry returns all settings but the protection and restore words to delivery values.
// - With index reset enabled a rising index edge clears the counter, otherwise not.
// - With external reset enabled a chosen latch edge clears the counter.
// - The up/down enable makes A a count pulse and B the direction instead of quadrature.
// - Edge select 0 picks the falling latch edge, 1 the rising one, reset value 1.
// - A workpiece counts as detected only once the count moved more than the filter value.
// - Modes 0 and 1 take both latch edges with rising and falling count direction.
// - Modes 2 and 3 take only rising latch edges with rising and falling count.
// - Modes 4 and 5 take only falling latch edges; higher values are invalid.
module ecc_top
  import ecc_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Object write and read port
  input wire logic i_obj_wr,
  input wire logic i_obj_rd,
  input wire logic [23:0] i_obj_addr,
  input wire logic [31:0] i_obj_wdata,
  output logic [31:0] o_obj_rdata,
  output logic o_obj_rvalid,
  output logic o_obj_err,
  // Nonvolatile store handshake
  input wire logic i_store_ack,
  output logic o_store_req,
  output logic o_save_inhibit_mode,
  // Encoder pins
  input wire ecc_trk_s i_trk,
  // Counter state
  output logic [31:0] o_count,
  output logic o_workpiece_detected,
  output logic [31:0] o_measure_value,
  output logic o_measure_valid
);

  // Configuration and store state
  ecc_cfg_s cfg;
  ecc_cfg_s next_cfg;
  logic [31:0] protect_word;
  logic [31:0] next_protect_word;
  logic [31:0] restore_word;
  logic [31:0] next_restore_word;
  logic save_inhibit_mode;
  logic next_save_inhibit_mode;
  logic store_req;
  logic next_store_req;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic err;
  logic next_err;
  logic cfg_write;

  // Synchronised track levels and edges
  logic [3:0] lvl;
  logic [3:0] rise;
  logic [3:0] fall;

  // Counter and measurement state
  logic [31:0] count;
  logic [31:0] next_count;
  logic [31:0] anchor;
  logic [31:0] next_anchor;
  logic detected;
  logic next_detected;
  logic [31:0] meas_val;
  logic [31:0] next_meas_val;
  logic meas_vld;
  logic next_meas_vld;
  logic [31:0] moved;
  logic step_up;
  logic step_dn;
  logic index_reset;
  logic ext_reset;
  logic meas_edge;
  logic meas_dir_ok;

  // Tracks enter as {a, b, index, latch}
  ecc_sync #(
    .WIDTH(4)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_pin({i_trk.a, i_trk.b, i_trk.index, i_trk.latch}),
    .o_level(lvl),
    .o_rise(rise),
    .o_fall(fall)
  );

  // Object store
  always_comb begin
    next_cfg = cfg;
    next_protect_word = protect_word;
    next_restore_word = restore_word;
    next_save_inhibit_mode = save_inhibit_mode;
    next_store_req = store_req && !i_store_ack;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_err = 1'b0;
    cfg_write = 1'b0;
    // A write wins over a read in the same cycle; the read is dropped
    if (i_obj_wr) begin
      case (i_obj_addr)
        ECC_ADDR_PROTECT: begin
          // Any other value ends inhibition at once
          next_protect_word = i_obj_wdata;
          next_save_inhibit_mode = (i_obj_wdata == ECC_PROTECT_CODE);
        end
        ECC_ADDR_RESTORE: begin
          // The word is kept so the master reads back what it wrote
          next_restore_word = i_obj_wdata;
          if (i_obj_wdata == ECC_RESTORE_CODE) begin
            next_cfg = ECC_CFG_DEFAULT;
            cfg_write = 1'b1;
          end
        end
        ECC_ADDR_IDX_RST: begin
          next_cfg.index_reset_enable = i_obj_wdata[0];
          cfg_write = 1'b1;
        end
        ECC_ADDR_EXT_RST: begin
          next_cfg.latch_input_reset_enable = i_obj_wdata[0];
          cfg_write = 1'b1;
        end
        ECC_ADDR_UPDOWN: begin
          next_cfg.updown_count_enable = i_obj_wdata[0];
          cfg_write = 1'b1;
        end
        ECC_ADDR_EDGE_SEL: begin
          next_cfg.latch_reset_edge_select = i_obj_wdata[0];
          cfg_write = 1'b1;
        end
        ECC_ADDR_FILTER: begin
          next_cfg.workpiece_filter_count = i_obj_wdata;
          cfg_write = 1'b1;
        end
        ECC_ADDR_MEAS: begin
          // Invalid modes are refused so the edge logic never sees them
          if (i_obj_wdata[15:0] <= ECC_MEAS_MAX) begin
            next_cfg.edge_measure_select = i_obj_wdata[15:0];
            cfg_write = 1'b1;
          end else begin
            next_err = 1'b1;
          end
        end
        // Unmapped addresses answer with an error pulse and change nothing
        default: next_err = 1'b1;
      endcase
    end else if (i_obj_rd) begin
      next_rvalid = 1'b1;
      case (i_obj_addr)
        ECC_ADDR_PROTECT: next_rdata = protect_word;
        ECC_ADDR_RESTORE: next_rdata = restore_word;
        ECC_ADDR_IDX_RST: next_rdata = {31'h0, cfg.index_reset_enable};
        ECC_ADDR_EXT_RST: next_rdata = {31'h0, cfg.latch_input_reset_enable};
        ECC_ADDR_UPDOWN: next_rdata = {31'h0, cfg.updown_count_enable};
        ECC_ADDR_EDGE_SEL: next_rdata = {31'h0, cfg.latch_reset_edge_select};
        ECC_ADDR_FILTER: next_rdata = cfg.workpiece_filter_count;
        ECC_ADDR_MEAS: next_rdata = {16'h0, cfg.edge_measure_select};
        default: begin
          next_rdata = 32'h0;
          next_err = 1'b1;
        end
      endcase
    end
    // Save request only when changes may reach nonvolatile storage
    // Set wins over the acknowledge so a write in the ack cycle is not lost
    if (cfg_write && !next_save_inhibit_mode) begin
      next_store_req = 1'b1;
    end
  end

  // Restart clears inhibition since the flag is volatile
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cfg <= ECC_CFG_DEFAULT;
      protect_word <= ECC_RST_PROTECT;
      restore_word <= ECC_RST_RESTORE;
      save_inhibit_mode <= 1'b0;
      store_req <= 1'b0;
      rdata <= 32'h0;
      rvalid <= 1'b0;
      err <= 1'b0;
    end else begin
      cfg <= next_cfg;
      protect_word <= next_protect_word;
      restore_word <= next_restore_word;
      save_inhibit_mode <= next_save_inhibit_mode;
      store_req <= next_store_req;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      err <= next_err;
    end
  end

  // Step decoding and the position counter
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    if (cfg.updown_count_enable) begin
      // A is the count pulse, B high counts down
      step_up = rise[3] && !lvl[2];
      step_dn = rise[3] && lvl[2];
    end else begin
      // Both edges of A with B as direction; B edges are ignored to keep the decoder small
      step_up = (rise[3] && !lvl[2]) || (fall[3] && lvl[2]);
      step_dn = (rise[3] && lvl[2]) || (fall[3] && !lvl[2]);
    end
    index_reset = cfg.index_reset_enable && rise[1];
    // Edge select only matters while the external reset is enabled
    ext_reset = cfg.latch_input_reset_enable &&
                (cfg.latch_reset_edge_select ? rise[0] : fall[0]);
    next_count = count;
    // Index wins when both reset sources fire in one cycle
    if (index_reset) begin
      next_count = ECC_RST_COUNT;
    end else if (ext_reset) begin
      next_count = ECC_RST_COUNT;
    end else if (step_up) begin
      next_count = count + 32'h1;
    end else if (step_dn) begin
      next_count = count - 32'h1;
    end
  end

  // Counter wraps at 32 bits; the master reads it as unsigned
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      count <= ECC_RST_COUNT;
    end else begin
      count <= next_count;
    end
  end

  // Workpiece measurement
  always_comb begin
    case (cfg.edge_measure_select)
      16'h0000, 16'h0001: meas_edge = rise[0] || fall[0];
      16'h0002, 16'h0003: meas_edge = rise[0];
      16'h0004, 16'h0005: meas_edge = fall[0];
      // Invalid codes are refused on write; this branch only guards
      default: meas_edge = 1'b0;
    endcase
    // Odd modes measure with a falling count
    meas_dir_ok = cfg.edge_measure_select[0] ? step_dn : step_up;
    // Distance includes this cycle's step, so the step that passes the filter counts
    moved = cfg.edge_measure_select[0] ? (anchor - next_count) : (next_count - anchor);
    next_anchor = anchor;
    next_detected = detected;
    next_meas_val = meas_val;
    next_meas_vld = 1'b0;
    // A new edge restarts the distance from the current count
    if (meas_edge) begin
      next_anchor = count;
      next_detected = 1'b0;
      next_meas_val = count;
      next_meas_vld = 1'b1;
    end else if (meas_dir_ok && !detected && moved > cfg.workpiece_filter_count) begin
      next_detected = 1'b1;
    end
  end

  // Anchor holds the count at the last measured edge
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      anchor <= ECC_RST_COUNT;
      detected <= 1'b0;
      meas_val <= 32'h0;
      meas_vld <= 1'b0;
    end else begin
      anchor <= next_anchor;
      detected <= next_detected;
      meas_val <= next_meas_val;
      meas_vld <= next_meas_vld;
    end
  end

  assign o_obj_rdata = rdata;
  assign o_obj_rvalid = rvalid;
  assign o_obj_err = err;
  assign o_store_req = store_req;
  assign o_save_inhibit_mode = save_inhibit_mode;
  assign o_count = count;
  assign o_workpiece_detected = detected;
  assign o_measure_value = meas_val;
  assign o_measure_valid = meas_vld;

endmodule : ecc_top
`default_nettype wire

// *** verification/ecc_top_assertions.sv ***
// Checker for the encoder configuration block: store, inhibit, modes, count.
// Sees only top-level ports; bound into ecc_top below.
`timescale 1ns/100ps
`default_nettype none
module ecc_chk
  import ecc_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Object port
  input wire logic i_obj_wr,
  input wire logic [23:0] i_obj_addr,
  input wire logic [31:0] i_obj_wdata,
  input wire logic o_obj_err,
  // Store and counter
  input wire logic i_store_ack,
  input wire logic o_store_req,
  input wire logic o_save_inhibit_mode,
  input wire logic [31:0] o_count,
  input wire logic o_measure_valid
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic wp;
  logic wm;
  assign wp = i_obj_wr && i_obj_addr == ECC_ADDR_PROTECT;
  assign wm = i_obj_wr && i_obj_addr == ECC_ADDR_MEAS;
  chk_inhibit_set: assert property (
    wp && i_obj_wdata == ECC_PROTECT_CODE |=> o_save_inhibit_mode) else $error("no inhibit");
  chk_inhibit_end: assert property (
    wp && i_obj_wdata != ECC_PROTECT_CODE |=> !o_save_inhibit_mode) else $error("inhibit kept");
  chk_save_blocked: assert property (
    o_save_inhibit_mode && !o_store_req && !wp |=> !o_store_req) else $error("save while inhibited");
  chk_req_hold: assert property (
    o_store_req && !i_store_ack |=> o_store_req) else $error("request dropped");
  chk_req_clear: assert property (
    o_store_req && i_store_ack && !i_obj_wr |=> !o_store_req) else $error("request stuck");
  chk_mode_refused: assert property (
    wm && i_obj_wdata[15:0] > ECC_MEAS_MAX |=> o_obj_err) else $error("bad mode taken");
  chk_mode_taken: assert property (
    wm && i_obj_wdata[15:0] <= ECC_MEAS_MAX |=> !o_obj_err) else $error("good mode refused");
  chk_edge_once: assert property (
    o_measure_valid |=> !o_measure_valid) else $error("double edge");
  chk_count_step: assert property (
    !$stable(o_count) |-> o_count == $past(o_count) + 32'h1 ||
    o_count == $past(o_count) - 32'h1 || o_count == 32'h0) else $error("count jump");
endmodule : ecc_chk
bind ecc_top ecc_chk u_chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_obj_wr(i_obj_wr),
  .i_obj_addr(i_obj_addr), .i_obj_wdata(i_obj_wdata), .o_obj_err(o_obj_err),
  .i_store_ack(i_store_ack), .o_store_req(o_store_req),
  .o_save_inhibit_mode(o_save_inhibit_mode), .o_count(o_count),
  .o_measure_valid(o_measure_valid));
`default_nettype wire

// *** verification/ecc_enc_model.sv ***
// Encoder model: A/B tracks stepped on command, index and latch passed on.
// Assumes the bench commands one step per pulse of i_step.
`timescale 1ns/100ps
`default_nettype none
module ecc_enc_model
  import ecc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_step,
  input wire logic i_dir,
  input wire logic i_updown,
  input wire logic i_index,
  input wire logic i_latch,
  output ecc_trk_s o_trk
);
  logic [1:0] ph = 2'h0;
  always @(posedge i_ref_clk) begin
    if (i_step)
      ph <= i_dir ? ph - 2'h1 : ph + 2'h1;
  end
  // Up/down mode: A is a pulse train, B the direction level
  assign o_trk.a = i_updown ? ph[0] : ph[1];
  assign o_trk.b = i_updown ? i_dir : ph[1] ^ ph[0];
  assign o_trk.index = i_index;
  assign o_trk.latch = i_latch;
endmodule : ecc_enc_model
`default_nettype wire

// *** verification/ecc_top_tb.sv ***
// Self-checking bench for ecc_top with the encoder model on its pins.
// Assumes answers one cycle after the strobe and 3-flop pin latency.
`timescale 1ns/100ps
`default_nettype none
module ecc_top_tb
  import ecc_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ack = 1'b0;
  logic step = 1'b0, dir = 1'b0, ud = 1'b0, idx = 1'b0, lat = 1'b0;
  logic [23:0] addr = 24'h0;
  logic [31:0] wdata = 32'h0, rdata, count, v, mval;
  logic rvalid, err, req, inh, wpd, mvalid;
  ecc_trk_s trk;
  int err_count = 0, checks_done = 0, hits = 0, h;
  logic [23:0] at [8] = '{ECC_ADDR_PROTECT, ECC_ADDR_RESTORE, ECC_ADDR_IDX_RST,
    ECC_ADDR_EXT_RST, ECC_ADDR_UPDOWN, ECC_ADDR_EDGE_SEL, ECC_ADDR_FILTER, ECC_ADDR_MEAS};
  logic [31:0] dt [8] = '{0, 0, 0, 0, 0, 1, 0, 0};
  ecc_top i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_obj_wr(wr), .i_obj_rd(rd),
    .i_obj_addr(addr), .i_obj_wdata(wdata), .o_obj_rdata(rdata), .o_obj_rvalid(rvalid),
    .o_obj_err(err), .i_store_ack(ack), .o_store_req(req), .o_save_inhibit_mode(inh),
    .i_trk(trk), .o_count(count), .o_workpiece_detected(wpd),
    .o_measure_value(mval), .o_measure_valid(mvalid));
  ecc_enc_model i_enc (.i_ref_clk(clk), .i_step(step), .i_dir(dir), .i_updown(ud),
    .i_index(idx), .i_latch(lat), .o_trk(trk));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    if (mvalid === 1'b1)
      hits <= hits + 1;
  end
  function automatic logic meas_hit(input int m, input logic rising);
    return rising ? (m < 4) : (m < 2 || m > 3);
  endfunction : meas_hit
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrt(input logic [23:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wrt
  task automatic rdc(input logic [23:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({rvalid, rdata}, {1'b1, e});
  endtask : rdc
  // Two cycles per step so the synchroniser sees every level
  task automatic mv(input int n, input logic d);
    repeat (n) begin
      @(posedge clk);
      step <= 1'b1;
      dir <= d;
      @(posedge clk);
      step <= 1'b0;
    end
    repeat (6) @(posedge clk);
    #1;
  endtask : mv
  task automatic pin(input logic i, input logic l);
    @(posedge clk);
    idx <= i;
    lat <= l;
    repeat (6) @(posedge clk);
    #1;
  endtask : pin
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
  initial begin
    void'($urandom(27333));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      rdc(at[i], dt[i]);
    for (int i = 2; i < 7; i++) begin
      v = $urandom;
      wrt(at[i], v);
      rdc(at[i], i == 6 ? v : {31'h0, v[0]});
    end
    for (int m = 0; m < 8; m++) begin
      wrt(ECC_ADDR_MEAS, 32'(m));
      chk(err, m > 5);
      rdc(ECC_ADDR_MEAS, m > 5 ? 32'h5 : 32'(m));
    end
    wrt(ECC_ADDR_RESTORE, ECC_RESTORE_CODE);
    rdc(ECC_ADDR_RESTORE, ECC_RESTORE_CODE);
    for (int i = 2; i < 8; i++)
      rdc(at[i], dt[i]);
    wrt(ECC_ADDR_PROTECT, ECC_PROTECT_CODE);
    chk(inh, 1'b1);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    wrt(ECC_ADDR_FILTER, 32'h1);
    chk(req, 1'b0);
    wrt(ECC_ADDR_PROTECT, ECC_PROTECT_CODE ^ 32'h1);
    chk(inh, 1'b0);
    wrt(ECC_ADDR_FILTER, 32'h0);
    chk(req, 1'b1);
    wrt(ECC_ADDR_PROTECT, ECC_PROTECT_CODE);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(inh, 1'b0);
    mv(8, 1'b0);
    chk(count, 32'hfffffffc);
    mv(8, 1'b1);
    chk(count, 32'h0);
    wrt(ECC_ADDR_UPDOWN, 32'h1);
    ud <= 1'b1;
    mv(6, 1'b0);
    chk(count, 32'h3);
    mv(2, 1'b1);
    chk(count, 32'h2);
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b0);
    chk(count, 32'h2);
    wrt(ECC_ADDR_IDX_RST, 32'h1);
    pin(1'b1, 1'b0);
    chk(count, 32'h0);
    pin(1'b0, 1'b0);
    wrt(ECC_ADDR_IDX_RST, 32'h0);
    wrt(ECC_ADDR_EXT_RST, 32'h1);
    mv(2, 1'b0);
    pin(1'b0, 1'b1);
    chk(count, 32'h0);
    mv(2, 1'b0);
    pin(1'b0, 1'b0);
    chk(count, 32'h1);
    wrt(ECC_ADDR_EDGE_SEL, 32'h0);
    pin(1'b0, 1'b1);
    chk(count, 32'h1);
    pin(1'b0, 1'b0);
    chk(count, 32'h0);
    wrt(ECC_ADDR_EXT_RST, 32'h0);
    for (int m = 0; m < 6; m++) begin
      wrt(ECC_ADDR_MEAS, 32'(m));
      h = hits;
      pin(1'b0, 1'b1);
      chk(33'(hits - h), meas_hit(m, 1'b1));
      h = hits;
      pin(1'b0, 1'b0);
      chk(33'(hits - h), meas_hit(m, 1'b0));
    end
    wrt(ECC_ADDR_MEAS, 32'h0);
    wrt(ECC_ADDR_FILTER, 32'h2);
    pin(1'b0, 1'b1);
    chk(wpd, 1'b0);
    mv(2, 1'b0);
    chk(wpd, 1'b0);
    mv(2, 1'b0);
    chk(wpd, 1'b0);
    mv(2, 1'b0);
    chk(wpd, 1'b1);
    pin(1'b0, 1'b0);
    chk(mval, 32'h3);
    summarize();
  end
endmodule : ecc_top_tb
`default_nettype wire
